// *** hw/tprf_line_buf.sv ***
`timescale 1ns/1ps
module tprf_line_buf #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 320,
    parameter int AW    = 9
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_b,
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic [AW-1:0]    rd_addr,
    output logic      [WIDTH-1:0] rd_data
);

    if (DEPTH < 2 || DEPTH > (1 << AW)) begin : g_bad_depth
        $error("tprf_line_buf: DEPTH does not fit AW");
    end

    logic [WIDTH-1:0] mem [DEPTH];

    // Storage needs no reset; a row is always written before it is read
    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Registered read, one cycle of latency
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rd_data <= '0;
        end else begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule // tprf_line_buf

// *** hw/tprf_pix_fmt.sv ***
`timescale 1ns/1ps
module tprf_pix_fmt
    import tprf_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    tprf_pix_if.snk          pix,
    input  wire logic        sync_repurpose,
    input  wire logic        force_ones,
    output logic      [11:0] vid_data,
    output logic             vid_sat_sync,
    output logic             vid_valid,
    output logic             vid_hsync,
    output logic             vid_vsync
);

    // Ones are forced only when the pin no longer carries the flag
    wire force_now = sync_repurpose && force_ones && pix.sat;
    wire [11:0] next_data = force_now ? ALL_ONES : pix.data;
    // Flag per pixel, or frame sync once the pin is repurposed
    wire next_sat_sync = pix.valid && (sync_repurpose ? pix.sof : pix.sat);

    // Every video output leaves from a flop
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            vid_data     <= '0;
            vid_sat_sync <= 1'b0;
            vid_valid    <= 1'b0;
            vid_hsync    <= 1'b0;
            vid_vsync    <= 1'b0;
        end else begin
            vid_data     <= pix.valid ? next_data : '0;
            vid_sat_sync <= next_sat_sync;
            vid_valid    <= pix.valid;
            vid_hsync    <= pix.valid; // Rows come out unbroken
            vid_vsync    <= pix.frame;
        end
    end

endmodule // tprf_pix_fmt

// *** hw/tprf_pix_if.sv ***
`timescale 1ns/1ps
// One pixel on its way from the line buffers to the video formatter
interface tprf_pix_if;
    logic        valid;
    logic        sof;
    logic        frame;
    logic        sat;
    logic [11:0] data;

    modport src (output valid, output sof, output frame, output sat, output data);
    modport snk (input valid, input sof, input frame, input sat, input data);
endinterface

// *** hw/tprf_pkg.sv ***
package tprf_pkg;

    // Sample format
    localparam int          DATA_W         = 12;
    localparam int          PIX_W          = 13;
    localparam int          COORD_W        = 9;
    localparam logic [11:0] ALL_ONES       = 12'hFFF;

    // Active pixel field coordinates
    localparam logic [8:0]  COL_FIRST      = 9'h004;
    localparam logic [8:0]  COL_LAST       = 9'h143;
    localparam logic [8:0]  ROW_FIRST      = 9'h006;
    localparam logic [8:0]  ROW_LAST       = 9'h0F5;
    localparam logic [8:0]  ROW_MID_TOP    = 9'h07D;
    localparam logic [8:0]  ROW_MIRROR_SUM = 9'h0FB;
    localparam int          LINE_PIXELS    = 320;

    // Register indices; byte address is four times the index
    localparam logic [7:0]  IDX_COL_MIN    = 8'h96;
    localparam logic [7:0]  IDX_COL_MAX    = 8'h97;
    localparam logic [7:0]  IDX_ROW_MIN    = 8'h98;
    localparam logic [7:0]  IDX_ROW_MAX    = 8'h99;
    localparam logic [7:0]  IDX_VID_CFG    = 8'hCC;
    localparam logic [7:0]  IDX_CTRL       = 8'hE0;
    localparam logic [7:0]  IDX_STAT       = 8'hE1;
    localparam logic [7:0]  IDX_MASK       = 8'hE2;
    localparam logic [7:0]  IDX_STATE      = 8'hE3;

    // Field positions
    localparam int          VCFG_SYNC_REP  = 6;
    localparam int          VCFG_FORCE     = 7;
    localparam int          CTRL_START     = 0;
    localparam int          CTRL_CONT      = 1;
    localparam int          CTRL_BIN_H     = 2;
    localparam int          CTRL_COL_RED   = 3;
    localparam int          CTRL_ROW_RED   = 4;
    localparam int          CTRL_DUAL_PH   = 6;
    localparam int          CTRL_DUAL_HDR  = 7;
    localparam int          STAT_FRAME     = 0;
    localparam int          STAT_CONFLICT  = 1;
    localparam int          STAT_SAT       = 2;
    localparam int          STAT_W         = 3;

    // Values after reset
    localparam logic [7:0]  VID_CFG_RST    = 8'h00;
    localparam logic [7:0]  CTRL_RST       = 8'h00;
    localparam logic [2:0]  MASK_RST       = 3'h0;

    typedef enum logic [2:0] {
        TPRF_IDLE,
        TPRF_CONV,
        TPRF_EMIT_TOP,
        TPRF_EMIT_BOT,
        TPRF_ROW_NEXT
    } tprf_state_e;

endpackage

// *** hw/tprf_top.sv ***
// Decided for this implementation: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
// Operation
// - Each pixel leaves as a signed 12-bit gate difference plus a saturation bit.
// - Unless the pin is repurposed, every pixel carries its saturation flag on the sync/saturation pin.
// - Pin repurposed and force bit set: saturated pixels show 0xFFF on data.
// - Columns 4 to 323, rows 6 to 245, origin upper left.
// - Top and bottom halves read in parallel, from the middle rows outward.
// - Even columns convert first, then odd; video shows natural column order.
// - Frame time grows with window rows, transfer time with window columns.
// - The 160 by 30 window reaches the listed frame rates per mode.
// - Pixels grouped in 2x2 cells; equal cell positions driven identically.
// - Measurement drives upper and lower rows together, readout even and odd.
// - Window mirrored over both halves, starts even, ends odd.
module tprf_top
    import tprf_pkg::*;
#(
    parameter int LINE_DEPTH = LINE_PIXELS
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    // Classic Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [11:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             irq,
    // Measurement and column converter side
    input  wire logic        meas_req,
    output logic             meas_gate_upper,
    output logic             meas_gate_lower,
    output logic             conv_req,
    output logic             conv_parity,
    output logic             conv_bin_h,
    output logic      [8:0]  conv_col,
    output logic      [8:0]  conv_row_top,
    output logic      [8:0]  conv_row_bot,
    input  wire logic        conv_ack,
    input  wire logic [11:0] conv_top_data,
    input  wire logic        conv_top_sat,
    input  wire logic [11:0] conv_bot_data,
    input  wire logic        conv_bot_sat,
    // Parallel video port
    output logic      [11:0] vid_data,
    output logic             sync_saturation_pin,
    output logic             vid_valid,
    output logic             vid_hsync,
    output logic             vid_vsync
);

    if (LINE_DEPTH < LINE_PIXELS || LINE_DEPTH > 512) begin : g_bad_depth
        $error("tprf_top: LINE_DEPTH must hold a full row");
    end

    // Software registers
    logic [8:0]        win_col_min;
    logic [8:0]        win_col_max;
    logic [8:0]        win_row_min;
    logic [8:0]        win_row_max;
    logic [7:0]        vid_cfg;
    logic [7:0]        ctrl;
    logic [STAT_W-1:0] status;
    logic [STAT_W-1:0] mask;

    // Working copy of the window, frozen for one frame
    logic [8:0]        w_col_min;
    logic [8:0]        w_row_min;
    logic [8:0]        w_span;
    logic              w_col_red;
    logic [1:0]        w_row_code;

    tprf_state_e       state;
    logic [7:0]        conv_k;
    logic [8:0]        emit_addr;
    logic              first_row;
    logic              in_frame;
    logic              p_valid;
    logic              p_sel_bot;
    logic              p_sof;
    logic              p_frame;
    logic              frame_done;
    logic [PIX_W-1:0]  top_rd;
    logic [PIX_W-1:0]  bot_rd;

    // Bus decode; a write lands on the edge that samples ack, while the master still holds it
    wire        bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire        bus_wr    = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    wire [7:0]  bus_idx   = wb_adr_i[9:2];
    wire        bus_inmap = (wb_adr_i[11:10] == 2'b00);
    wire        sel_col_min = bus_inmap && (bus_idx == IDX_COL_MIN);
    wire        sel_col_max = bus_inmap && (bus_idx == IDX_COL_MAX);
    wire        sel_row_min = bus_inmap && (bus_idx == IDX_ROW_MIN);
    wire        sel_row_max = bus_inmap && (bus_idx == IDX_ROW_MAX);
    wire        sel_vid_cfg = bus_inmap && (bus_idx == IDX_VID_CFG);
    wire        sel_ctrl    = bus_inmap && (bus_idx == IDX_CTRL);
    wire        sel_stat    = bus_inmap && (bus_idx == IDX_STAT);
    wire        sel_mask    = bus_inmap && (bus_idx == IDX_MASK);
    wire        sel_state   = bus_inmap && (bus_idx == IDX_STATE);
    wire        busy        = (state != TPRF_IDLE);

    // Read view of the addressed register; unmapped reads as zero
    wire [31:0] rd_cur =
        sel_col_min ? {23'h0, win_col_min} :
        sel_col_max ? {23'h0, win_col_max} :
        sel_row_min ? {23'h0, win_row_min} :
        sel_row_max ? {23'h0, win_row_max} :
        sel_vid_cfg ? {24'h0, vid_cfg} :
        sel_ctrl    ? {24'h0, ctrl[7:1], 1'b0} :
        sel_stat    ? {29'h0, status} :
        sel_mask    ? {29'h0, mask} :
        sel_state   ? {7'h0, conv_row_top, 15'h0, busy} :
        32'h0000_0000;

    // Byte lanes not selected keep the old contents
    wire [31:0] lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire [31:0] wr_merged = (wb_dat_i & lane_mask) | (rd_cur & ~lane_mask);

    // Window corners forced to even start and odd end
    wire [8:0]  wr_even = {wr_merged[8:1], 1'b0};
    wire [8:0]  wr_odd  = {wr_merged[8:1], 1'b1};

    wire        start_wr  = bus_wr && sel_ctrl && wb_sel_i[0] && wb_dat_i[CTRL_START];
    wire [STAT_W-1:0] stat_clr = (bus_wr && sel_stat && wb_sel_i[0]) ? wb_dat_i[STAT_W-1:0] : '0;

    // Binning is suppressed in dual modes and the conflict is flagged
    wire        dual_on   = ctrl[CTRL_DUAL_PH] || ctrl[CTRL_DUAL_HDR];
    wire        bin_req   = ctrl[CTRL_BIN_H];
    wire        bin_ok    = bin_req && !dual_on;
    wire        conflict  = bin_req && dual_on;

    // Frame start: by software or on its own in continuous mode
    wire        row_more;
    wire        restart   = (state == TPRF_ROW_NEXT) && !row_more && ctrl[CTRL_CONT];
    wire        frame_go  = ((state == TPRF_IDLE) && start_wr) || restart;

    // Conversion walk: all even columns, then all odd ones unless reduced or binned
    wire        skip_odd  = w_col_red || conv_bin_h;
    wire        conv_xfer = conv_req && conv_ack;
    wire        k_last    = (conv_k == w_span[8:1]);
    wire        conv_last = k_last && (conv_parity || skip_odd);
    wire [8:0]  next_wr_addr = {conv_k, conv_parity};
    wire [7:0]  next_k    = k_last ? 8'h00 : 8'(conv_k + 8'h01);

    // Emission walk in natural column order, every second one if reduced or binned
    wire [8:0]  emit_end  = skip_odd ? {w_span[8:1], 1'b0} : w_span;
    wire        emit_last = (emit_addr == emit_end);
    wire [8:0]  emit_step = skip_odd ? 9'h002 : 9'h001;
    wire        emitting  = (state == TPRF_EMIT_TOP) || (state == TPRF_EMIT_BOT);

    // Row pairs from the middle outward, at the reduction step
    wire [8:0]  row_step  = 9'(9'h001 << w_row_code);
    wire [8:0]  row_left  = 9'(conv_row_top - w_row_min);
    assign      row_more  = (row_left >= row_step);
    wire [8:0]  next_top  = 9'(conv_row_top - row_step);

    wire [STAT_W-1:0] stat_set = {p_valid && (p_sel_bot ? bot_rd[PIX_W-1] : top_rd[PIX_W-1]),
                                  frame_go && conflict,
                                  frame_done};

    // Bus answer one cycle after the request, then ack drops
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? rd_cur : 32'h0000_0000;
        end
    end

    // Window registers, effective from the next frame start; a software start walks its first even pass from the old w_col_min
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            win_col_min <= COL_FIRST;
            win_col_max <= COL_LAST;
            win_row_min <= ROW_FIRST;
            win_row_max <= ROW_MID_TOP;
        end else if (bus_wr) begin
            if (sel_col_min) win_col_min <= wr_even;
            if (sel_col_max) win_col_max <= wr_odd;
            if (sel_row_min) win_row_min <= wr_even;
            if (sel_row_max) win_row_max <= wr_odd;
        end
    end

    // Configuration and control; the start bit never stores
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            vid_cfg <= VID_CFG_RST;
            ctrl    <= CTRL_RST;
            mask    <= MASK_RST;
        end else if (bus_wr) begin
            if (sel_vid_cfg) vid_cfg <= wr_merged[7:0];
            if (sel_ctrl)    ctrl    <= {wr_merged[7:1], 1'b0};
            if (sel_mask)    mask    <= wr_merged[STAT_W-1:0];
        end
    end

    // Sticky events; a new event wins over a clear in the same cycle
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            status <= '0;
            irq    <= 1'b0;
        end else begin
            status <= (status & ~stat_clr) | stat_set;
            irq    <= |(((status & ~stat_clr) | stat_set) & mask);
        end
    end

    // Both halves of every 2x2 cell get the same measurement gating
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            meas_gate_upper <= 1'b0;
            meas_gate_lower <= 1'b0;
        end else begin
            meas_gate_upper <= meas_req;
            meas_gate_lower <= meas_req;
        end
    end

    // Readout sequencer
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state <= TPRF_IDLE;
        end else begin
            unique case (state)
                TPRF_IDLE: begin
                    if (frame_go) state <= TPRF_CONV;
                end
                TPRF_CONV: begin
                    if (conv_xfer && conv_last) state <= TPRF_EMIT_TOP;
                end
                TPRF_EMIT_TOP: begin
                    if (emit_last) state <= TPRF_EMIT_BOT;
                end
                TPRF_EMIT_BOT: begin
                    if (emit_last) state <= TPRF_ROW_NEXT;
                end
                TPRF_ROW_NEXT: begin
                    if (row_more || restart) state <= TPRF_CONV;
                    else state <= TPRF_IDLE;
                end
            endcase
        end
    end

    // Frame setup latches the window; the bottom row mirrors the top one
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            w_col_min    <= COL_FIRST;
            w_row_min    <= ROW_FIRST;
            w_span       <= 9'(COL_LAST - COL_FIRST);
            w_col_red    <= 1'b0;
            w_row_code   <= 2'b00;
            conv_bin_h   <= 1'b0;
            conv_row_top <= ROW_MID_TOP;
            conv_row_bot <= 9'(ROW_MIRROR_SUM - ROW_MID_TOP);
            first_row    <= 1'b0;
        end else if (frame_go) begin
            w_col_min    <= win_col_min;
            w_row_min    <= win_row_min;
            w_span       <= 9'(win_col_max - win_col_min);
            w_col_red    <= ctrl[CTRL_COL_RED];
            w_row_code   <= ctrl[CTRL_ROW_RED +: 2];
            conv_bin_h   <= bin_ok;
            conv_row_top <= win_row_max;
            conv_row_bot <= 9'(ROW_MIRROR_SUM - win_row_max);
            first_row    <= 1'b1;
        end else if (state == TPRF_ROW_NEXT && row_more) begin
            conv_row_top <= next_top;
            conv_row_bot <= 9'(ROW_MIRROR_SUM - next_top);
            first_row    <= 1'b0;
        end
    end

    // Converter request stays up until the last column of the row pair
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            conv_req    <= 1'b0;
            conv_k      <= 8'h00;
            conv_parity <= 1'b0;
            conv_col    <= COL_FIRST;
        end else if ((state == TPRF_IDLE && frame_go) || (state == TPRF_ROW_NEXT && (row_more || restart))) begin
            conv_req    <= 1'b1;
            conv_k      <= 8'h00;
            conv_parity <= 1'b0;
            conv_col    <= restart ? win_col_min : w_col_min;
        end else if (conv_xfer) begin
            conv_req    <= !conv_last;
            conv_k      <= next_k;
            conv_parity <= conv_parity ^ k_last;
            conv_col    <= k_last ? 9'(w_col_min + 9'h001) : 9'(conv_col + 9'h002);
        end
    end

    // Emission address and frame level
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            emit_addr  <= 9'h000;
            in_frame   <= 1'b0;
            frame_done <= 1'b0;
        end else begin
            emit_addr  <= (emitting && !emit_last) ? 9'(emit_addr + emit_step) : 9'h000;
            frame_done <= (state == TPRF_ROW_NEXT) && !row_more;
            if (frame_go) in_frame <= 1'b1;
            else if (state == TPRF_ROW_NEXT && !row_more) in_frame <= 1'b0;
        end
    end

    // Flags registered on the same edge as the buffer read, so they line up with its data
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            p_valid   <= 1'b0;
            p_sel_bot <= 1'b0;
            p_sof     <= 1'b0;
            p_frame   <= 1'b0;
        end else begin
            p_valid   <= emitting;
            p_sel_bot <= (state == TPRF_EMIT_BOT);
            p_sof     <= (state == TPRF_EMIT_TOP) && first_row && (emit_addr == 9'h000);
            p_frame   <= in_frame;
        end
    end

    // Row pair buffers, written in conversion order, read in column order
    tprf_line_buf #(.WIDTH(PIX_W), .DEPTH(LINE_DEPTH), .AW(COORD_W)) u_top_buf (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .wr_en   (conv_xfer),
        .wr_addr (next_wr_addr),
        .wr_data ({conv_top_sat, conv_top_data}),
        .rd_addr (emit_addr),
        .rd_data (top_rd)
    );

    tprf_line_buf #(.WIDTH(PIX_W), .DEPTH(LINE_DEPTH), .AW(COORD_W)) u_bot_buf (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .wr_en   (conv_xfer),
        .wr_addr (next_wr_addr),
        .wr_data ({conv_bot_sat, conv_bot_data}),
        .rd_addr (emit_addr),
        .rd_data (bot_rd)
    );

    // Top row of the pair goes out first, then its mirrored bottom row
    tprf_pix_if pix ();
    assign pix.valid = p_valid;
    assign pix.sof   = p_sof;
    assign pix.frame = p_frame;
    assign pix.sat   = p_sel_bot ? bot_rd[PIX_W-1] : top_rd[PIX_W-1];
    assign pix.data  = p_sel_bot ? bot_rd[DATA_W-1:0] : top_rd[DATA_W-1:0];

    tprf_pix_fmt u_fmt (
        .clk_sys        (clk_sys),
        .rst_b          (rst_b),
        .pix            (pix),
        .sync_repurpose (vid_cfg[VCFG_SYNC_REP]),
        .force_ones     (vid_cfg[VCFG_FORCE]),
        .vid_data       (vid_data),
        .vid_sat_sync   (sync_saturation_pin),
        .vid_valid      (vid_valid),
        .vid_hsync      (vid_hsync),
        .vid_vsync      (vid_vsync)
    );

endmodule // tprf_top

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module testbench;
    import tprf_pkg::*;
    logic        clk_sys, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq, meas_req, clr;
    logic        meas_gate_upper, meas_gate_lower, conv_req, conv_ack, conv_top_sat, conv_bot_sat;
    logic        sync_saturation_pin, vid_valid, conv_bin_h;
    logic [11:0] wb_adr_i, conv_top_data, conv_bot_data, vid_data;
    logic [31:0] wb_dat_i, wb_dat_o, rdat;
    logic [8:0]  conv_col, conv_row_top, conv_row_bot;
    int          error_cnt, tests_run, cyc_cnt;

    tprf_top tprf_top_i (.clk_sys, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'hF),
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq, .meas_req, .meas_gate_upper, .meas_gate_lower, .conv_req,
        .conv_parity(), .conv_bin_h, .conv_col, .conv_row_top, .conv_row_bot, .conv_ack, .conv_top_data,
        .conv_top_sat, .conv_bot_data, .conv_bot_sat, .vid_data, .sync_saturation_pin, .vid_valid,
        .vid_hsync(), .vid_vsync());
    tprf_capture tprf_capture_i (.clk_sys, .clr, .vid_valid, .sat(sync_saturation_pin), .data(vid_data));

    // Converter ack is the request delayed one cycle; row and column are folded into the sample to trace order
    always @(posedge clk_sys) conv_ack <= conv_req;
    assign conv_top_data = {conv_row_top[1:0], 1'b0, conv_col};
    assign conv_bot_data = {conv_row_bot[1:0], 1'b1, conv_col};
    assign conv_top_sat  = conv_col[1:0] == 2'b11;
    assign conv_bot_sat  = conv_col[1:0] == 2'b10;

    initial begin
        clk_sys = 0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // A hang ends the run as a failure
    always @(posedge clk_sys) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            error_cnt++;
            test_done();
        end
    end

    task automatic wb(input logic w, input logic [7:0] idx, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_sys);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
        wb_adr_i <= {2'b00, idx, 2'b00};
        wb_dat_i <= d;
        do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, idx, d, q);
    endtask

    // Window is columns 4..11, top rows 124..125: two row pairs of sixteen pixels each
    task automatic frame(input logic [31:0] ctrl, input logic force_on);
        logic [8:0]  c, r;
        logic [11:0] d;
        logic        s;
        int          k;
        k = 0;
        clr <= 1;
        @(posedge clk_sys);
        clr <= 0;
        wr(IDX_CTRL, ctrl & ~32'h1); // Start frames with the modes already stored
        wr(IDX_CTRL, ctrl);
        do wb(1'b0, IDX_STAT, 0, rdat); while (rdat[STAT_FRAME] !== 1'b1);
        `CHK(tprf_capture_i.cnt, 32)
        for (int p = 0; p < 2; p++) for (int h = 0; h < 2; h++) for (c = 4; c < 12; c++) begin
            r = h ? 126 + p : 125 - p;
            d = {r[1:0], h[0], c};
            s = h ? c[1:0] == 2'b10 : c[1:0] == 2'b11;
            if (force_on) `CHK(tprf_capture_i.mem[k][12:0], {k == 0, s ? ALL_ONES : d})
            else `CHK(tprf_capture_i.mem[k][12:0], {s, d})
            k++;
        end
    endtask

    task automatic t_reset;
        logic [7:0]  ix [6] = '{8'h96, 8'h97, 8'h98, 8'h99, 8'h9A, 8'hCC};
        logic [31:0] ex [6] = '{32'h4, 32'h143, 32'h6, 32'h7D, 32'h0, 32'h0};
        for (int i = 0; i < 6; i++) begin
            wb(1'b0, ix[i], 0, rdat);
            `CHK(rdat, ex[i])
        end
        wr(IDX_COL_MIN, 32'h5);
        wb(1'b0, IDX_COL_MIN, 0, rdat);
        `CHK(rdat, 32'h4)
        wr(IDX_COL_MAX, 32'hB);
        wr(IDX_ROW_MIN, 32'h7C);
        meas_req <= 1;
        repeat (2) @(posedge clk_sys);
        `CHK({meas_gate_upper, meas_gate_lower}, 2'b11)
        meas_req <= 0;
        $display("reset and map test done");
    endtask

    task automatic t_frame;
        wr(IDX_MASK, 32'h1);
        frame(32'h1, 1'b0);
        `CHK(irq, 1'b1)
        `CHK(rdat[2:0], 3'b101)
        wr(IDX_STAT, 32'h7);
        repeat (3) @(posedge clk_sys);
        `CHK(irq, 1'b0)
        $display("natural order frame test done");
    endtask

    // Masked events must leave the interrupt low
    task automatic t_force;
        wr(IDX_MASK, 32'h2);
        wr(IDX_VID_CFG, 32'hC0);
        frame(32'h1, 1'b1);
        `CHK(irq, 1'b0)
        wr(IDX_STAT, 32'h7);
        wr(IDX_VID_CFG, 32'h0);
        $display("forced ones test done");
    endtask

    // Binning asked in dual phase mode is refused, so the odd pass still runs
    task automatic t_conflict;
        frame(32'h45, 1'b0);
        `CHK(rdat[STAT_CONFLICT], 1'b1)
        `CHK(conv_bin_h, 1'b0)
        `CHK(irq, 1'b1)
        wr(IDX_STAT, 32'h7);
        $display("binning conflict test done");
    endtask

    task test_done;
        $display("tests run %0d, errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    initial begin
        {rst_b, wb_cyc_i, wb_stb_i, wb_we_i, meas_req, clr} = 0;
        wb_adr_i = 0;
        wb_dat_i = 0;
        repeat (6) @(posedge clk_sys);
        rst_b <= 1;
        t_reset();
        t_frame();
        t_force();
        t_conflict();
        test_done();
    end
endmodule // testbench

// *** tb/tprf_capture.sv ***
`timescale 1ns/1ps
// Frame-capturing receiver on the video port; takes every valid pixel, no back-pressure
module tprf_capture (
    input wire logic        clk_sys,
    input wire logic        clr,
    input wire logic        vid_valid,
    input wire logic        sat,
    input wire logic [11:0] data
);
    logic [15:0] mem [0:63];
    int          cnt;

    // Pads 13 bits into one 16-bit word; index wraps, so frames above 64 pixels overwrite
    always @(posedge clk_sys) begin
        if (clr) begin
            cnt <= 0;
        end else if (vid_valid === 1'b1) begin
            mem[cnt[5:0]] <= {3'h0, sat, data};
            cnt <= cnt + 1;
        end
    end
endmodule // tprf_capture

// *** tb/tprf_chk_assertions.sv ***
`timescale 1ns/1ps
module tprf_chk
    import tprf_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        rst_b,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic        meas_gate_upper,
    input wire logic        meas_gate_lower,
    input wire logic        conv_req,
    input wire logic        conv_parity,
    input wire logic [8:0]  conv_col,
    input wire logic [8:0]  conv_row_top,
    input wire logic [8:0]  conv_row_bot,
    input wire logic [11:0] vid_data,
    input wire logic        vid_valid,
    input wire logic        vid_hsync,
    input wire logic        vid_vsync
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    // Bus answers exactly one cycle after taking a request, for one cycle
    chk_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
    chk_ack_single: assert property ($rose(wb_ack_o) |=> !wb_ack_o) else $error("ack too long");
    chk_gate_pair: assert property (meas_gate_upper == meas_gate_lower)
        else $error("gates differ");
    chk_row_mirror: assert property (conv_row_bot == ROW_MIRROR_SUM - conv_row_top)
        else $error("bottom row not mirrored");
    chk_row_field: assert property (conv_row_top >= ROW_FIRST && conv_row_top <= ROW_MID_TOP)
        else $error("top row outside half");
    chk_col_field: assert property (conv_req |-> conv_col >= COL_FIRST && conv_col <= COL_LAST)
        else $error("column outside field");
    chk_pass_parity: assert property (conv_req |-> conv_col[0] == conv_parity)
        else $error("column parity mismatch");
    chk_hsync_row: assert property (vid_hsync == vid_valid && (!vid_valid || vid_vsync))
        else $error("row framing broken");
    chk_data_idle: assert property (!vid_valid |-> vid_data == 12'h000)
        else $error("data outside pixel");
endmodule // tprf_chk

bind tprf_top tprf_chk tprf_chk_i (.clk_sys, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .meas_gate_upper,
    .meas_gate_lower, .conv_req, .conv_parity, .conv_col, .conv_row_top, .conv_row_bot, .vid_data,
    .vid_valid, .vid_hsync, .vid_vsync);
